/* rtl/mrs_pkg.sv */
// Constants and carrier types for the receive frame statistics block.
// Assumes one 125 MHz system clock and a synchronous active-high reset.

package mrs_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned CNT_W   = 32;
  localparam int unsigned RUNT_W  = 10;
  localparam int unsigned LEN_W   = 16;
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned NUM_CNT = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [15:0] OFS_MULTICAST_RX_OK  = 16'h0045;
  localparam logic [15:0] OFS_RX_LEN_64        = 16'h0046;
  localparam logic [15:0] OFS_RX_LEN_65_127    = 16'h0047;
  localparam logic [15:0] OFS_RX_LEN_128_255   = 16'h0048;
  localparam logic [15:0] OFS_RX_LEN_256_511   = 16'h0049;
  localparam logic [15:0] OFS_RX_LEN_512_1023  = 16'h004a;
  localparam logic [15:0] OFS_RX_LEN_1024_UP   = 16'h004b;
  localparam logic [15:0] OFS_RX_RUNT_DROP     = 16'h004c;

  // ****************************************
  // Counter slots, in offset order
  // ****************************************
  localparam logic [2:0] IDX_MCAST    = 3'h0;
  localparam logic [2:0] IDX_LEN_64   = 3'h1;
  localparam logic [2:0] IDX_LEN_65   = 3'h2;
  localparam logic [2:0] IDX_LEN_128  = 3'h3;
  localparam logic [2:0] IDX_LEN_256  = 3'h4;
  localparam logic [2:0] IDX_LEN_512  = 3'h5;
  localparam logic [2:0] IDX_LEN_1024 = 3'h6;
  localparam logic [2:0] IDX_RUNT     = 3'h7;

  // ****************************************
  // Length bin edges and limits
  // ****************************************
  localparam logic [15:0] LEN_64   = 16'h0040;
  localparam logic [15:0] LEN_128  = 16'h0080;
  localparam logic [15:0] LEN_256  = 16'h0100;
  localparam logic [15:0] LEN_512  = 16'h0200;
  localparam logic [15:0] LEN_1024 = 16'h0400;
  localparam logic [31:0] CNT_MAX  = 32'hffff_ffff;
  localparam logic [31:0] RUNT_MAX = 32'h0000_03ff;
  localparam logic [31:0] RST_CNT  = 32'h0000_0000;

  // ****************************************
  // Carriers and state
  // ****************************************
  typedef struct packed {
    logic              done;
    logic              good;
    logic              mcast;
    logic [LEN_W-1:0]  len;
  } mrs_rx_evt_t;

  typedef struct packed {
    logic              rd;
    logic [ADDR_W-1:0] addr;
  } mrs_rd_req_t;

  typedef struct packed {
    logic [CNT_W-1:0]  rd_data;
    logic              rd_valid;
  } mrs_reg_state_t;

endpackage

/* rtl/mrs_rx_stats.sv */
// Receive frame statistics: multicast, length bins and runt counters.
// Assumes the MAC gives one done strobe per frame, same clock, with
// length, good and multicast flags valid in that cycle.

module mrs_rx_stats (
  input  wire logic                 sys_clk_in,
  input  wire logic                 reset_in,
  input  wire mrs_pkg::mrs_rx_evt_t rx_evt_in,
  input  wire mrs_pkg::mrs_rd_req_t rd_req_in,
  output logic               [31:0] rd_data_out,
  output logic                      rd_valid_out
);

  // ****************************************
  // Frame classification
  // ****************************************
  logic                        runt_w;
  logic                        good_w;
  logic [mrs_pkg::NUM_CNT-1:0] inc_w;
  logic [mrs_pkg::NUM_CNT-1:0] clr_w;
  logic                 [31:0] cnt_w [mrs_pkg::NUM_CNT];
  logic                        hit_w;
  logic                  [2:0] idx_w;

  assign runt_w = rx_evt_in.done && (rx_evt_in.len < mrs_pkg::LEN_64);
  // Runts are dropped, never good, even if the MAC flags them so
  assign good_w = rx_evt_in.done && rx_evt_in.good && !runt_w;

  always_comb
  begin
    inc_w[mrs_pkg::IDX_MCAST]    = good_w && rx_evt_in.mcast;
    inc_w[mrs_pkg::IDX_LEN_64]   = good_w && (rx_evt_in.len == mrs_pkg::LEN_64);
    inc_w[mrs_pkg::IDX_LEN_65]   = good_w && (rx_evt_in.len > mrs_pkg::LEN_64)
                                 && (rx_evt_in.len < mrs_pkg::LEN_128);
    inc_w[mrs_pkg::IDX_LEN_128]  = good_w && (rx_evt_in.len >= mrs_pkg::LEN_128)
                                 && (rx_evt_in.len < mrs_pkg::LEN_256);
    inc_w[mrs_pkg::IDX_LEN_256]  = good_w && (rx_evt_in.len >= mrs_pkg::LEN_256)
                                 && (rx_evt_in.len < mrs_pkg::LEN_512);
    inc_w[mrs_pkg::IDX_LEN_512]  = good_w && (rx_evt_in.len >= mrs_pkg::LEN_512)
                                 && (rx_evt_in.len < mrs_pkg::LEN_1024);
    inc_w[mrs_pkg::IDX_LEN_1024] = good_w && (rx_evt_in.len >= mrs_pkg::LEN_1024);
    inc_w[mrs_pkg::IDX_RUNT]     = runt_w;
  end

  // ****************************************
  // Read decode
  // ****************************************
  assign hit_w = rd_req_in.rd
               && (rd_req_in.addr >= mrs_pkg::OFS_MULTICAST_RX_OK)
               && (rd_req_in.addr <= mrs_pkg::OFS_RX_RUNT_DROP);
  assign idx_w = 3'(rd_req_in.addr - mrs_pkg::OFS_MULTICAST_RX_OK);
  assign clr_w = hit_w ? (8'h01 << idx_w) : 8'h00;

  // ****************************************
  // Counters
  // ****************************************
  for (genvar i = 0; i < mrs_pkg::NUM_CNT; i++)
  begin : g_cnt
    localparam int unsigned W = (i == mrs_pkg::IDX_RUNT) ? mrs_pkg::RUNT_W : mrs_pkg::CNT_W;
    logic [W-1:0] val;

    mrs_sat_counter #(
      .WIDTH (W)
    ) u_cnt (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .inc_in     (inc_w[i]),
      .clr_in     (clr_w[i]),
      .count_out  (val)
    );

    assign cnt_w[i] = 32'(val);
  end

  // ****************************************
  // Read data register
  // ****************************************
  mrs_pkg::mrs_reg_state_t st_q;
  mrs_pkg::mrs_reg_state_t st_d;

  always_comb
  begin
    st_d          = st_q;
    st_d.rd_valid = rd_req_in.rd;
    if (rd_req_in.rd)
    begin
      // Value before the clear; unmapped offsets read zero
      st_d.rd_data = hit_w ? cnt_w[idx_w] : mrs_pkg::RST_CNT;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rd_data_out  = st_q.rd_data;
  assign rd_valid_out = st_q.rd_valid;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  property p_mcast_inc;
    inc_w[0] && !clr_w[0] && (cnt_w[0] != mrs_pkg::CNT_MAX)
      |=> cnt_w[0] == $past(cnt_w[0]) + 32'h0000_0001;
  endproperty
  a_mcast_inc: assert property (p_mcast_inc) else $error("multicast not counted");

  property p_mcast_only_flag;
    rx_evt_in.done && !rx_evt_in.mcast && !clr_w[0] |=> $stable(cnt_w[0]);
  endproperty
  a_mcast_only_flag: assert property (p_mcast_only_flag) else $error("unicast counted");

  property p_mcast_sat;
    (cnt_w[0] == mrs_pkg::CNT_MAX) && !clr_w[0] |=> cnt_w[0] == mrs_pkg::CNT_MAX;
  endproperty
  a_mcast_sat: assert property (p_mcast_sat) else $error("multicast wrapped");

  property p_read_clears;
    hit_w && !inc_w[idx_w] |=> cnt_w[$past(idx_w)] == 32'h0000_0000;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  property p_len64;
    rx_evt_in.done && rx_evt_in.good && (rx_evt_in.len == 16'h0040) && !clr_w[1]
      && (cnt_w[1] != mrs_pkg::CNT_MAX) |=> cnt_w[1] == $past(cnt_w[1]) + 32'h0000_0001;
  endproperty
  a_len64: assert property (p_len64) else $error("64 byte bin missed");

  property p_len65;
    rx_evt_in.done && rx_evt_in.good && (rx_evt_in.len == 16'h0041) && !clr_w[2]
      && (cnt_w[2] != mrs_pkg::CNT_MAX) ##1 1'b1 ##0 (cnt_w[1] == $past(cnt_w[1]))
      |-> cnt_w[2] == $past(cnt_w[2]) + 32'h0000_0001;
  endproperty
  a_len65: assert property (p_len65) else $error("65-127 bin missed");

  property p_len127_edge;
    rx_evt_in.done && rx_evt_in.good && (rx_evt_in.len == 16'h007f) && !clr_w[3]
      |=> $stable(cnt_w[3]);
  endproperty
  a_len127_edge: assert property (p_len127_edge) else $error("127 in wrong bin");

  property p_len128;
    rx_evt_in.done && rx_evt_in.good && (rx_evt_in.len == 16'h0080) && !clr_w[3]
      && (cnt_w[3] != mrs_pkg::CNT_MAX) |=> cnt_w[3] == $past(cnt_w[3]) + 32'h0000_0001;
  endproperty
  a_len128: assert property (p_len128) else $error("128-255 bin missed");

  property p_len511;
    rx_evt_in.done && rx_evt_in.good && (rx_evt_in.len == 16'h01ff) && !clr_w[4]
      && (cnt_w[4] != mrs_pkg::CNT_MAX) |=> cnt_w[4] == $past(cnt_w[4]) + 32'h0000_0001;
  endproperty
  a_len511: assert property (p_len511) else $error("256-511 bin missed");

  property p_len1023;
    rx_evt_in.done && rx_evt_in.good && (rx_evt_in.len == 16'h03ff) && !clr_w[5]
      && (cnt_w[5] != mrs_pkg::CNT_MAX) |=> cnt_w[5] == $past(cnt_w[5]) + 32'h0000_0001;
  endproperty
  a_len1023: assert property (p_len1023) else $error("512-1023 bin missed");

  property p_len_big;
    rx_evt_in.done && rx_evt_in.good && (rx_evt_in.len >= 16'h0400) && !clr_w[6]
      && (cnt_w[6] != mrs_pkg::CNT_MAX) |=> cnt_w[6] == $past(cnt_w[6]) + 32'h0000_0001;
  endproperty
  a_len_big: assert property (p_len_big) else $error("1024+ bin missed");

  property p_bad_no_bin;
    rx_evt_in.done && !rx_evt_in.good && (clr_w == 8'h00) |=> $stable(cnt_w[6])
      && $stable(cnt_w[1]) && $stable(cnt_w[0]);
  endproperty
  a_bad_no_bin: assert property (p_bad_no_bin) else $error("bad frame binned");

  property p_runt;
    rx_evt_in.done && (rx_evt_in.len == 16'h003f) && !clr_w[7]
      && (cnt_w[7] != mrs_pkg::RUNT_MAX) |=> cnt_w[7] == $past(cnt_w[7]) + 32'h0000_0001;
  endproperty
  a_runt: assert property (p_runt) else $error("runt not counted");

  property p_runt_sat;
    (cnt_w[7] == mrs_pkg::RUNT_MAX) && !clr_w[7] |=> cnt_w[7] == mrs_pkg::RUNT_MAX;
  endproperty
  a_runt_sat: assert property (p_runt_sat) else $error("runt wrapped");

  property p_runt_upper;
    hit_w && (idx_w == 3'h7) |=> rd_valid_out && (rd_data_out[31:10] == 22'h00_0000);
  endproperty
  a_runt_upper: assert property (p_runt_upper) else $error("runt upper bits set");

  property p_rd_value;
    hit_w |=> rd_valid_out && (rd_data_out == $past(cnt_w[idx_w]));
  endproperty
  a_rd_value: assert property (p_rd_value) else $error("read data wrong");

  property p_race;
    hit_w && inc_w[idx_w] |=> cnt_w[$past(idx_w)] == 32'h0000_0001;
  endproperty
  a_race: assert property (p_race) else $error("event lost on read");

  c_race: cover property (hit_w && inc_w[idx_w]);
  c_runt_full: cover property (cnt_w[7] == mrs_pkg::RUNT_MAX);
  c_big_frame: cover property (inc_w[6] ##1 hit_w && (idx_w == 3'h6));
  c_mcast_read: cover property (inc_w[0] ##[1:4] hit_w && (idx_w == 3'h0));

endmodule

/* rtl/mrs_sat_counter.sv */
// Saturating, clear-on-read event counter.
// Assumes inc_in and clr_in are same-clock single-cycle strobes.

module mrs_sat_counter #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  input  wire logic             inc_in,
  input  wire logic             clr_in,
  output logic      [WIDTH-1:0] count_out
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } mrs_cnt_state_t;

  mrs_cnt_state_t st_q;
  mrs_cnt_state_t st_d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_d = st_q;
    if (clr_in)
    begin
      st_d.count = inc_in ? WIDTH'(1) : '0;
    end
    else if (inc_in && (st_q.count != {WIDTH{1'b1}}))
    begin
      st_d.count = st_q.count + WIDTH'(1);
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign count_out = st_q.count;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  property p_sat_hold;
    (count_out == {WIDTH{1'b1}}) && !clr_in |=> count_out == {WIDTH{1'b1}};
  endproperty
  a_sat_hold: assert property (p_sat_hold) else $error("counter wrapped");

  property p_clr_race;
    clr_in && inc_in |=> count_out == WIDTH'(1);
  endproperty
  a_clr_race: assert property (p_clr_race) else $error("event lost on clear");

  property p_clr_zero;
    clr_in && !inc_in |=> count_out == '0;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("read did not clear");

  property p_reset_zero;
    @(posedge sys_clk_in) disable iff (1'b0) reset_in |=> count_out == '0;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("not zero after reset");

endmodule

/* tb/mrs_host_model.sv */
// Host model: issues single register reads to the statistics block.
// Assumes the bench calls rd() from one process at a time.

module mrs_host_model (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rd_valid_in,
  input  wire logic          [31:0] rd_data_in,
  output mrs_pkg::mrs_rd_req_t      rd_req_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial rd_req_out = '0;

  // ****************************************
  // Read cycle
  // ****************************************
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic v);
    @(posedge sys_clk_in);
    rd_req_out <= '{rd: 1'b1, addr: a};
    @(posedge sys_clk_in);
    rd_req_out.rd <= 1'b0;
    // Stale address scrambled, never left looking valid
    rd_req_out.addr <= ~a;
    @(posedge sys_clk_in);
    v = rd_valid_in;
    d = rd_data_in;
  endtask
endmodule

/* tb/tb_mrs_rx_stats.sv */
// Self-checking bench for the receive frame statistics block.
// Assumes the host model in the same folder and the design package.

module tb_mrs_rx_stats;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk;
  logic                 rst;
  mrs_pkg::mrs_rx_evt_t rx;
  mrs_pkg::mrs_rd_req_t rq;
  logic          [31:0] rdd;
  logic                 rdv;
  logic          [31:0] exp_q [8];
  logic          [31:0] r;
  logic          [15:0] lens [13];
  int                   seed;
  int                   fail_count;
  int                   cmp_count;
  int                   cyc;

  mrs_rx_stats i_mrs_rx_stats (
    .sys_clk_in   (clk),
    .reset_in     (rst),
    .rx_evt_in    (rx),
    .rd_req_in    (rq),
    .rd_data_out  (rdd),
    .rd_valid_out (rdv)
  );

  mrs_host_model i_mrs_host_model (
    .sys_clk_in  (clk),
    .rd_valid_in (rdv),
    .rd_data_in  (rdd),
    .rd_req_out  (rq)
  );

  always #4 clk = ~clk;

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    // Whole run needs about 3800 cycles
    if (cyc == 20000)
    begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    cmp_count++;
    if (got !== ex)
    begin
      fail_count++;
      $display("BAD %0t: got %h want %h", $time, got, ex);
    end
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] ex);
    logic [31:0] d;
    logic        v;
    i_mrs_host_model.rd(a, d, v);
    chk({31'h0, v}, 32'h1);
    chk(d, ex);
  endtask

  function automatic int bin(logic [15:0] l);
    if (l < 64) return 7;
    if (l == 64) return 1;
    if (l < 128) return 2;
    if (l < 256) return 3;
    if (l < 512) return 4;
    if (l < 1024) return 5;
    return 6;
  endfunction

  // ****************************************
  // Frame events and expectation
  // ****************************************
  task automatic evt(input logic g, input logic m, input logic [15:0] l);
    int i;
    @(posedge clk);
    rx <= '{done: 1'b1, good: g, mcast: m, len: l};
    @(posedge clk);
    rx.done <= 1'b0;
    i = bin(l);
    // Runts ignore good and are never multicast
    if (i == 7)
    begin
      if (exp_q[7] != 32'h0000_03ff) exp_q[7]++;
    end
    else if (g)
    begin
      exp_q[i]++;
      if (m) exp_q[0]++;
    end
  endtask

  task automatic all_chk;
    for (int i = 0; i < 8; i++)
    begin
      rdchk(mrs_pkg::OFS_MULTICAST_RX_OK + 16'(i), exp_q[i]);
      exp_q[i] = '0;
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 15;
    clk = 1'b0;
    rst = 1'b1;
    rx = '0;
    fail_count = 0;
    cmp_count = 0;
    cyc = 0;
    foreach (exp_q[i]) exp_q[i] = '0;
    lens = '{16'h003f, 16'h0040, 16'h0041, 16'h007f, 16'h0080, 16'h00ff, 16'h0100,
             16'h01ff, 16'h0200, 16'h03ff, 16'h0400, 16'hffff, 16'h0000};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    all_chk();
    foreach (lens[k]) evt(1'b1, k[0], lens[k]);
    evt(1'b0, 1'b1, 16'h0064);
    all_chk();
    repeat (40)
    begin
      repeat (8)
      begin
        r = $random(seed);
        evt(r[20], r[21], {5'h00, r[10:0]});
      end
      all_chk();
    end
    rdchk(16'h0044, 32'h0000_0000);
    rdchk(16'h004d, 32'h0000_0000);
    repeat (1030) evt(1'b1, 1'b1, 16'h003f);
    rdchk(mrs_pkg::OFS_RX_RUNT_DROP, 32'h0000_03ff);
    rdchk(mrs_pkg::OFS_RX_RUNT_DROP, 32'h0000_0000);
    rdchk(mrs_pkg::OFS_MULTICAST_RX_OK, 32'h0000_0000);
    evt(1'b1, 1'b0, 16'h0040);
    fork
      evt(1'b1, 1'b0, 16'h0040);
      rdchk(mrs_pkg::OFS_RX_LEN_64, 32'h0000_0001);
    join
    rdchk(mrs_pkg::OFS_RX_LEN_64, 32'h0000_0001);
    evt(1'b1, 1'b1, 16'h012c);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (exp_q[i]) exp_q[i] = '0;
    all_chk();
    test_done();
  end
endmodule
